// >>> bss_map.vh
// Address map, option values and timing counts of the boot source selector
`ifndef BSS_MAP_VH
`define BSS_MAP_VH
`define BSS_ADDR_ROP 16'h4800
`define BSS_ADDR_CHSEL 16'h4815
`define BSS_ADDR_CHSEL_INV 16'h4816
`define BSS_ADDR_BLEN 16'h487e
`define BSS_ADDR_BLEN_INV 16'h487f
`define BSS_ADDR_MARKER 16'h8000
`define BSS_ROP_RESET 8'h00
`define BSS_ROP_OPEN 8'h00
`define BSS_CHSEL_RESET 16'hffff
`define BSS_CHSEL_ROUTE0 16'h11ee
`define BSS_BLEN_RESET 8'h00
`define BSS_BLEN_ON 8'h55
`define BSS_BLEN_INV_ON 8'haa
`define BSS_MARK_A 8'h82
`define BSS_MARK_B 8'hac
`define BSS_ILLEGAL_OP 8'h71
`define BSS_CLK_MHZ 250
`define BSS_SLOT_MS 4
`define BSS_SLOT_CYC (`BSS_SLOT_MS * `BSS_CLK_MHZ * 1000)
`define BSS_WIN_MS 1000
`define BSS_WIN_CYC (`BSS_WIN_MS * `BSS_CLK_MHZ * 1000)
`define BSS_INIT_MS 10
`define BSS_SYNC_CHAR 8'h7f
`endif

// >>> bss_boot_source_selector.v
// Boot start-up decision and UART receive channel polling
`timescale 1ns/10ps
// What this block does
// - Reads of unused boot ROM space return the illegal-opcode byte 0x71.
// - Boot permission comes from enable byte 0x487e and its inverse 0x487f.
// - One UART, several routings; listen on routing zero only when configured, or autodetect.
// - After reset autodetect is the default, polling the receive channels in turn from routing zero.
// - Autodetect examines each receive line alone for a 4 ms slot.
// - A receive line held low is skipped when autodetect moves on; routing zero is always polled first.
// - Channel-select word 0x11ee at 0x4815 restricts polling to routing zero.
// - Loader allowed only while read-out protection byte at 0x4800 is 0x00.
// - First program byte not 0x82 or 0xac means virgin: enter loader.
// - Marker present and enable pair 0x55/0xaa: enter loader.
// - Marker present, enable pair not set: jump to application.
// - Virgin memory: wait for a host with no time limit.
// - Programmed memory: listen one second, then jump to application.
`include "bss_map.vh"
module bss_boot_source_selector #(
	parameter SLOT_CYC = `BSS_SLOT_CYC,
	parameter WIN_CYC = `BSS_WIN_CYC
) (
	input wire sys_clk,
	input wire rst_b,
	input wire opt_wr,
	input wire [15:0] opt_addr,
	input wire [7:0] opt_wdata,
	output reg [7:0] opt_rdata_reg,
	input wire [7:0] prog_first_byte,
	input wire [15:0] rom_addr,
	input wire rom_used,
	input wire [7:0] rom_code,
	output reg [7:0] rom_rdata_reg,
	input wire [3:0] uart_rx,
	input wire [3:0] sync_seen,
	output reg [3:0] uart_route_reg,
	output reg listen_reg,
	output reg loader_active_reg,
	output reg app_jump_reg,
	output reg blocked_reg
);
	localparam S_ROP = 6'b000001;
	localparam S_MARK = 6'b000010;
	localparam S_POLL = 6'b000100;
	localparam S_LOAD = 6'b001000;
	localparam S_APP = 6'b010000;
	localparam S_BLOCK = 6'b100000;
	reg [5:0] state_reg;
	reg [7:0] rop_reg;
	reg [7:0] chsel_lo_reg;
	reg [7:0] chsel_hi_reg;
	reg [7:0] blen_reg;
	reg [7:0] blen_inv_reg;
	reg timed_reg;
	reg [1:0] chan_reg;
	reg [31:0] slot_cnt_reg;
	reg [31:0] win_cnt_reg;
	wire [15:0] chsel_word;
	wire route0_only;
	wire is_marked;
	wire boot_allowed;
	reg [1:0] next_chan;
	integer k;
	assign chsel_word = {chsel_hi_reg, chsel_lo_reg};
	assign route0_only = (chsel_word == `BSS_CHSEL_ROUTE0);
	assign is_marked = (prog_first_byte == `BSS_MARK_A) ||
		(prog_first_byte == `BSS_MARK_B);
	assign boot_allowed = (blen_reg == `BSS_BLEN_ON) &&
		(blen_inv_reg == `BSS_BLEN_INV_ON);
	function [3:0] onehot_route;
		input [1:0] idx;
		begin
			onehot_route = 4'h1 << idx;
		end
	endfunction
	// Next line in rotation skipping lines held low
	always @* begin
		next_chan = chan_reg;
		for (k = 3; k >= 1; k = k - 1) begin
			if (uart_rx[chan_reg + k[1:0]]) begin
				next_chan = chan_reg + k[1:0];
			end
		end
	end
	// Option bytes are non-volatile: reset leaves them, writes work in reset
	always @(posedge sys_clk) begin
		if (opt_wr) begin
			case (opt_addr)
			`BSS_ADDR_ROP: rop_reg <= opt_wdata;
			`BSS_ADDR_CHSEL: chsel_hi_reg <= opt_wdata;
			`BSS_ADDR_CHSEL_INV: chsel_lo_reg <= opt_wdata;
			`BSS_ADDR_BLEN: blen_reg <= opt_wdata;
			`BSS_ADDR_BLEN_INV: blen_inv_reg <= opt_wdata;
			default: ;
			endcase
		end
	end
	// Option byte read port
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			opt_rdata_reg <= 8'h00;
		end else begin
			case (opt_addr)
			`BSS_ADDR_ROP: opt_rdata_reg <= rop_reg;
			`BSS_ADDR_CHSEL: opt_rdata_reg <= chsel_hi_reg;
			`BSS_ADDR_CHSEL_INV: opt_rdata_reg <= chsel_lo_reg;
			`BSS_ADDR_BLEN: opt_rdata_reg <= blen_reg;
			`BSS_ADDR_BLEN_INV: opt_rdata_reg <= blen_inv_reg;
			default: opt_rdata_reg <= 8'h00;
			endcase
		end
	end
	// Boot ROM read with illegal-opcode fill
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rom_rdata_reg <= `BSS_ILLEGAL_OP;
		end else if (rom_used) begin
			rom_rdata_reg <= rom_code;
		end else begin
			rom_rdata_reg <= `BSS_ILLEGAL_OP;
		end
	end
	// Start-up sequencer and polling
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= S_ROP;
			timed_reg <= 1'b0;
			chan_reg <= 2'd0;
			slot_cnt_reg <= 32'd0;
			win_cnt_reg <= 32'd0;
			uart_route_reg <= 4'h0;
			listen_reg <= 1'b0;
			loader_active_reg <= 1'b0;
			app_jump_reg <= 1'b0;
			blocked_reg <= 1'b0;
		end else begin
			case (state_reg)
			S_ROP: begin
				if (rop_reg == `BSS_ROP_OPEN) begin
					state_reg <= S_MARK;
				end else begin
					state_reg <= S_BLOCK;
				end
			end
			S_MARK: begin
				chan_reg <= 2'd0;
				slot_cnt_reg <= 32'd0;
				win_cnt_reg <= 32'd0;
				if (!is_marked) begin
					timed_reg <= 1'b0;
					state_reg <= S_POLL;
				end else if (boot_allowed) begin
					timed_reg <= 1'b1;
					state_reg <= S_POLL;
				end else begin
					state_reg <= S_APP;
				end
			end
			S_POLL: begin
				listen_reg <= 1'b1;
				uart_route_reg <= onehot_route(chan_reg);
				if (|(sync_seen & uart_route_reg)) begin
					state_reg <= S_LOAD;
					listen_reg <= 1'b0;
				end else if (timed_reg && win_cnt_reg >= WIN_CYC - 1) begin
					state_reg <= S_APP;
					listen_reg <= 1'b0;
					uart_route_reg <= 4'h0;
				end else begin
					if (timed_reg) begin
						win_cnt_reg <= win_cnt_reg + 32'd1;
					end
					if (route0_only) begin
						chan_reg <= 2'd0;
					end else if (slot_cnt_reg >= SLOT_CYC - 1) begin
						slot_cnt_reg <= 32'd0;
						chan_reg <= next_chan;
					end else begin
						slot_cnt_reg <= slot_cnt_reg + 32'd1;
					end
				end
			end
			S_LOAD: begin
				loader_active_reg <= 1'b1;
			end
			S_APP: begin
				app_jump_reg <= 1'b1;
			end
			S_BLOCK: begin
				blocked_reg <= 1'b1;
				app_jump_reg <= 1'b1;
			end
			default: state_reg <= S_ROP;
			endcase
		end
	end
endmodule // bss_boot_source_selector

// >>> bss_monitor.sv
// Port checker of the boot source selector
`timescale 1ns/10ps
module bss_monitor (
	input wire sys_clk,
	input wire rst_b,
	input wire rom_used,
	input wire [7:0] rom_code,
	input wire [7:0] rom_rdata_reg,
	input wire [3:0] uart_rx,
	input wire [3:0] sync_seen,
	input wire [3:0] uart_route_reg,
	input wire listen_reg,
	input wire loader_active_reg,
	input wire app_jump_reg,
	input wire blocked_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence enter_seq;
		!listen_reg ##1 loader_active_reg;
	endsequence
	rom_fill_a: assert property (!rom_used |=> rom_rdata_reg == 8'h71)
		else $error("rom fill wrong");
	rom_pass_a: assert property (rom_used |=> rom_rdata_reg == $past(rom_code))
		else $error("rom data wrong");
	route_hot_a: assert property (listen_reg |-> $onehot(uart_route_reg))
		else $error("route not one-hot");
	route_skip_a: assert property (listen_reg && $past(listen_reg) &&
		$changed(uart_route_reg) |-> |(uart_route_reg & $past(uart_rx)))
		else $error("low line polled");
	sync_enter_a: assert property (listen_reg &&
		|(sync_seen & uart_route_reg) |=> enter_seq)
		else $error("sync not taken");
	flag_excl_a: assert property (!(loader_active_reg && app_jump_reg))
		else $error("loader and app both");
	block_quiet_a: assert property (blocked_reg |-> !listen_reg)
		else $error("listen while blocked");
	poll_order_a: assert property ($rose(listen_reg) |->
		!app_jump_reg && !blocked_reg && uart_route_reg == 4'h1)
		else $error("poll start wrong");
endmodule // bss_monitor
bind bss_boot_source_selector bss_monitor bss_monitor_i (.sys_clk(sys_clk),
	.rst_b(rst_b), .rom_used(rom_used), .rom_code(rom_code),
	.rom_rdata_reg(rom_rdata_reg), .uart_rx(uart_rx), .sync_seen(sync_seen),
	.uart_route_reg(uart_route_reg), .listen_reg(listen_reg),
	.loader_active_reg(loader_active_reg), .app_jump_reg(app_jump_reg),
	.blocked_reg(blocked_reg));

// >>> bss_host_model.sv
// Host loader on the receive lines
`timescale 1ns/10ps
module bss_host_model (
	input wire sys_clk,
	input wire [3:0] lines,
	input wire [3:0] host,
	input wire go,
	input wire [3:0] uart_route_reg,
	output reg [3:0] uart_rx,
	output reg [3:0] sync_seen
);
	// Sync sent only once the bench allows it
	always @(posedge sys_clk) begin
		uart_rx <= lines;
		sync_seen <= go ? (host & uart_route_reg) : 4'h0;
	end
endmodule // bss_host_model

// >>> bss_boot_source_selector_tb.sv
// Testbench of the boot source selector
`timescale 1ns/10ps
module bss_boot_source_selector_tb;
	reg sys_clk = 0, rst_b = 0, opt_wr = 0, rom_used = 0, go = 0;
	reg [15:0] opt_addr = 0, rom_addr = 0;
	reg [7:0] opt_wdata = 0, prog_first_byte = 0, rom_code = 0, pb;
	reg [3:0] lines = 4'h9, host = 4'h8;
	wire [7:0] opt_rdata_reg, rom_rdata_reg;
	wire [3:0] uart_rx, sync_seen, uart_route_reg;
	wire listen_reg, loader_active_reg, app_jump_reg, blocked_reg;
	integer failures = 0, check_count = 0, i;
	always #2 sys_clk = ~sys_clk;
	bss_boot_source_selector #(.SLOT_CYC(8), .WIN_CYC(100))
		bss_boot_source_selector_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.opt_wr(opt_wr), .opt_addr(opt_addr), .opt_wdata(opt_wdata),
		.opt_rdata_reg(opt_rdata_reg), .prog_first_byte(prog_first_byte),
		.rom_addr(rom_addr), .rom_used(rom_used), .rom_code(rom_code),
		.rom_rdata_reg(rom_rdata_reg), .uart_rx(uart_rx),
		.sync_seen(sync_seen), .uart_route_reg(uart_route_reg),
		.listen_reg(listen_reg), .loader_active_reg(loader_active_reg),
		.app_jump_reg(app_jump_reg), .blocked_reg(blocked_reg));
	bss_host_model bss_host_model_i (.sys_clk(sys_clk), .lines(lines),
		.host(host), .go(go), .uart_route_reg(uart_route_reg),
		.uart_rx(uart_rx), .sync_seen(sync_seen));
	task chk(input [7:0] got, input [7:0] exp);
		begin
		check_count = check_count + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
		end
	endtask
	task give_verdict;
		begin
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
		end
	endtask
	task wr(input [15:0] a, input [7:0] d);
		begin
		opt_addr = a;
		opt_wdata = d;
		opt_wr = 1;
		@(negedge sys_clk);
		opt_wr = 0;
		@(negedge sys_clk);
		end
	endtask
	task boot(input [7:0] b, input [7:0] readout_protect_option, input [15:0] sel,
		input [7:0] en, input [7:0] en_inv);
		begin
		rst_b = 0;
		go = 0;
		prog_first_byte = b;
		wr(16'h4800, readout_protect_option);
		wr(16'h4815, sel[15:8]);
		wr(16'h4816, sel[7:0]);
		wr(16'h487e, en);
		wr(16'h487f, en_inv);
		repeat (10) @(negedge sys_clk);
		rst_b = 1;
		repeat (4) @(negedge sys_clk);
		end
	endtask
	function [7:0] rom_exp(input u, input [7:0] c);
		rom_exp = u ? c : 8'h71;
	endfunction
	initial begin
		i = $urandom(28663);
		pb = $urandom;
		if (pb == 8'h82 || pb == 8'hac)
			pb = 8'h00;
		boot(pb, 8'h00, 16'hffff, 8'h00, 8'h00);
		chk(listen_reg, 1);
		chk(uart_route_reg, 8'h01);
		for (i = 0; i < 20; i = i + 1) begin
			rom_used = $urandom;
			rom_code = $urandom;
			rom_addr = $urandom;
			@(negedge sys_clk);
			chk(rom_rdata_reg, rom_exp(rom_used, rom_code));
		end
		opt_addr = 16'h487e;
		opt_wdata = $urandom;
		opt_wr = 1;
		@(negedge sys_clk);
		opt_wr = 0;
		@(negedge sys_clk);
		chk(opt_rdata_reg, opt_wdata);
		opt_addr = 16'h1234;
		@(negedge sys_clk);
		chk(opt_rdata_reg, 8'h00);
		repeat (150) @(negedge sys_clk);
		chk({listen_reg, app_jump_reg}, 8'h02);
		go = 1;
		for (i = 0; i < 200 && !loader_active_reg; i = i + 1)
			@(negedge sys_clk);
		chk(loader_active_reg, 1);
		boot(8'h82, 8'h00, 16'hffff, 8'h00, 8'h00);
		for (i = 0; i < 200 && !app_jump_reg; i = i + 1)
			@(negedge sys_clk);
		chk({app_jump_reg, loader_active_reg}, 8'h02);
		boot(8'hac, 8'h00, 16'hffff, 8'h55, 8'haa);
		chk(listen_reg, 1);
		for (i = 0; i < 200 && !app_jump_reg; i = i + 1)
			@(negedge sys_clk);
		chk({app_jump_reg, loader_active_reg}, 8'h02);
		boot(pb, 8'h01, 16'hffff, 8'h00, 8'h00);
		chk({blocked_reg, listen_reg}, 8'h02);
		boot(pb, 8'h00, 16'h11ee, 8'h00, 8'h00);
		go = 1;
		repeat (50) @(negedge sys_clk);
		chk({uart_route_reg, loader_active_reg}, 8'h02);
		give_verdict;
	end
endmodule // bss_boot_source_selector_tb
